// [rtl/pmw_pkg.sv]
// Package of constants for the power management wake control block
// How it works
// - Control register readable in every power state
// - Writes ignored until one read seen
// - State field: normal, wake-frame, energy detect
// - Byte-order test write wakes the device
// - Transceiver reset held 100us, self-clears
// - Writes to reset bit ignored while high
// - Wake frame raises interrupt and gated pin
// - Energy event raises interrupt and gated pin
// - Drive type: open-drain active low, push-pull
// - Push-pull polarity bit selects active level
// - Wake cause codes none, energy, frame, multiple
// - Cause clears by write-one only when ready
// - Cause stays while its event source persists
// - Pulse select: 50ms pulse or static level
// - Pin drops when cause or enable cleared
// - Pin enable gates pin, not interrupt
// - Ready bit shows device stabilised
package pmw_pkg;
    localparam logic [7:0]  PMW_OFS_CTRL      = 8'h84;
    localparam logic [7:0]  PMW_OFS_BYTE_TEST = 8'h64;
    localparam logic [7:0]  PMW_OFS_HARDWARE_CONFIG_REG    = 8'h74;
    localparam int          PMW_BIT_STATE     = 12;
    localparam int          PMW_BIT_XRST      = 10;
    localparam int          PMW_BIT_WFE       = 9;
    localparam int          PMW_BIT_EDE       = 8;
    localparam int          PMW_BIT_TYPE      = 6;
    localparam int          PMW_BIT_CAUSE     = 4;
    localparam int          PMW_BIT_PULSE     = 3;
    localparam int          PMW_BIT_POL       = 2;
    localparam int          PMW_BIT_PEN       = 1;
    localparam int          PMW_BIT_READY     = 0;
    localparam int          PMW_CLK_MHZ       = 100;
    localparam int          PMW_XRST_US       = 100;
    localparam int          PMW_XRST_CYC      = PMW_XRST_US * PMW_CLK_MHZ;
    localparam int          PMW_PULSE_MS      = 50;
    localparam int          PMW_PULSE_CYC     = PMW_PULSE_MS * 1000 * PMW_CLK_MHZ;
    localparam int          PMW_READY_CYC     = 64;
    localparam logic [1:0]  PMW_ST_NORMAL     = 2'h0;
    localparam logic [1:0]  PMW_ST_WAKE_FRAME = 2'h1;
    localparam logic [1:0]  PMW_ST_ENERGY     = 2'h2;
    localparam logic [31:0] PMW_RD_UNMAPPED   = 32'h00000000;
endpackage : pmw_pkg

// [rtl/pmw_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pmw_sync
    import pmw_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Pin level in and filtered level out
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } pmw_sync_s;

    pmw_sync_s st_r;
    pmw_sync_s st_nxt;

    // First stage is read only by the second; level moves when stages two and three agree
    always_comb begin
        st_nxt       = st_r;
        st_nxt.stage = {st_r.stage[1:0], pin_in};
        if (st_r.stage[1] == st_r.stage[2]) begin
            st_nxt.level = st_r.stage[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.level;
endmodule : pmw_sync

// [rtl/pmw_timer.sv]
// Down-counting interval timer with start and abort
`timescale 1ns/10ps
module pmw_timer
    import pmw_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [WIDTH-1:0] cycles,
    // Status
    output logic                  busy
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             busy;
    } pmw_timer_s;

    pmw_timer_s st_r;
    pmw_timer_s st_nxt;

    // Start wins over abort so a fresh request is never lost
    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.count = cycles;
            st_nxt.busy  = 1'b1;
        end else if (abort) begin
            st_nxt.busy = 1'b0;
        end else if (st_r.busy) begin
            if (st_r.count <= WIDTH'(1)) begin
                st_nxt.busy = 1'b0;
            end
            st_nxt.count = st_r.count - WIDTH'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;
endmodule : pmw_timer

// [rtl/pmw_wake_ctrl.sv]
// Power state, transceiver reset and wake-event pin control
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module pmw_wake_ctrl
    import pmw_pkg::*;
#(
    parameter int XRST_CYC  = PMW_XRST_CYC,
    parameter int PULSE_CYC = PMW_PULSE_CYC,
    parameter int READY_CYC = PMW_READY_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Event sources, pins from the detectors
    input  wire logic        wake_frame_event,
    input  wire logic        energy_event,
    // Transceiver reset and power state
    output logic             transceiver_reset,
    output logic [1:0]       power_state,
    output logic             device_ready,
    // Wake indications
    output logic             wake_interrupt,
    output logic             wake_event_pin_o,
    output logic             wake_event_pin_oe
);
    typedef enum logic [2:0] {
        PMW_RUN   = 3'b001,
        PMW_SLEEP = 3'b010,
        PMW_SETTLE = 3'b100
    } pmw_mode_e;

    typedef struct packed {
        pmw_mode_e   mode;
        logic [1:0]  state;
        logic        read_seen;
        logic        wfe;
        logic        ede;
        logic        drive_type;
        logic [1:0]  cause;
        logic        pulse_sel;
        logic        pol;
        logic        pen;
        logic        ready;
        logic [15:0] settle;
        logic        active;
        logic        xrst;
        logic [31:0] xrst_len;
        logic [31:0] rdata;
        logic        pin_o;
        logic        pin_oe;
    } pmw_ctrl_s;

    pmw_ctrl_s st_r;
    pmw_ctrl_s st_nxt;

    logic wf_lvl;
    logic ed_lvl;
    logic xrst_busy;
    logic pulse_busy;
    logic xrst_start;
    logic pulse_start;
    logic pulse_abort;

    // Event inputs cross into the clock domain through three synchroniser flops and a filter flop
    pmw_sync u_sync_wf (
        .core_clk  (core_clk),
        .reset     (reset),
        .pin_in    (wake_frame_event),
        .level_out (wf_lvl)
    );

    pmw_sync u_sync_ed (
        .core_clk  (core_clk),
        .reset     (reset),
        .pin_in    (energy_event),
        .level_out (ed_lvl)
    );

    // Hold timer for the transceiver reset and width timer for the pin pulse
    pmw_timer u_xrst_tmr (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (xrst_start),
        .abort    (1'b0),
        .cycles   (32'(XRST_CYC)),
        .busy     (xrst_busy)
    );

    pmw_timer u_pulse_tmr (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (pulse_start),
        .abort    (pulse_abort),
        .cycles   (32'(PULSE_CYC)),
        .busy     (pulse_busy)
    );

    // Control register image as read back
    function automatic logic [31:0] ctrl_image(input pmw_ctrl_s s);
        logic [31:0] v;
        v = '0;
        v[PMW_BIT_STATE+1:PMW_BIT_STATE] = s.state;
        v[PMW_BIT_XRST]  = s.xrst;
        v[PMW_BIT_WFE]   = s.wfe;
        v[PMW_BIT_EDE]   = s.ede;
        v[PMW_BIT_TYPE]  = s.drive_type;
        v[PMW_BIT_CAUSE+1:PMW_BIT_CAUSE] = s.cause;
        v[PMW_BIT_PULSE] = s.pulse_sel;
        v[PMW_BIT_POL]   = s.pol;
        v[PMW_BIT_PEN]   = s.pen;
        v[PMW_BIT_READY] = s.ready;
        return v;
    endfunction : ctrl_image

    logic        wr_ok;
    logic        wr_ctrl;
    logic        wr_wake;
    logic        wf_hit;
    logic        ed_hit;
    logic [1:0]  clr;
    logic        pin_act;

    // Write qualification and event detection
    always_comb begin
        wr_ok   = reg_wr && st_r.read_seen;
        wr_ctrl = wr_ok && (reg_addr == PMW_OFS_CTRL) && st_r.ready;
        wr_wake = reg_wr && (reg_addr == PMW_OFS_BYTE_TEST) && (st_r.mode == PMW_SLEEP);
        wf_hit  = st_r.wfe && wf_lvl;
        ed_hit  = st_r.ede && ed_lvl;
        xrst_start  = wr_ctrl && reg_wdata[PMW_BIT_XRST] && !st_r.xrst;
        pulse_start = (wf_hit || ed_hit) && !st_r.active && st_r.pulse_sel;
        clr = (wr_ctrl && (st_r.mode == PMW_RUN)) ?
              reg_wdata[PMW_BIT_CAUSE+1:PMW_BIT_CAUSE] : 2'h0;
        pulse_abort = pulse_busy && !st_r.active;
    end

    // Main next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.xrst = xrst_busy || xrst_start;
        // Length of the running transceiver reset, watched by the length check
        st_nxt.xrst_len = st_r.xrst ? (st_r.xrst_len + 32'h00000001) : 32'h00000000;
        if (reg_rd) begin
            st_nxt.read_seen = 1'b1;
        end
        // Read data; control readable in any state
        if (reg_rd && reg_addr == PMW_OFS_CTRL) begin
            st_nxt.rdata = ctrl_image(st_r);
        end else begin
            st_nxt.rdata = PMW_RD_UNMAPPED;
        end
        if (wr_ctrl) begin
            st_nxt.wfe        = reg_wdata[PMW_BIT_WFE];
            st_nxt.ede        = reg_wdata[PMW_BIT_EDE];
            st_nxt.drive_type = reg_wdata[PMW_BIT_TYPE];
            st_nxt.pulse_sel  = reg_wdata[PMW_BIT_PULSE];
            st_nxt.pol        = reg_wdata[PMW_BIT_POL];
            st_nxt.pen        = reg_wdata[PMW_BIT_PEN];
            // Reserved code is refused so the state stays defined
            if (reg_wdata[PMW_BIT_STATE+1:PMW_BIT_STATE] != 2'h3) begin
                st_nxt.state = reg_wdata[PMW_BIT_STATE+1:PMW_BIT_STATE];
            end
        end
        // Cause: set wins over clear; a live source keeps its bit
        st_nxt.cause[0] = (st_r.cause[0] && !clr[0]) || ed_hit ||
                          (st_r.cause[0] && ed_lvl);
        st_nxt.cause[1] = (st_r.cause[1] && !clr[1]) || wf_hit ||
                          (st_r.cause[1] && wf_lvl);
        case (st_r.mode)
            PMW_RUN: begin
                if (wr_ctrl && st_nxt.state != PMW_ST_NORMAL) begin
                    st_nxt.mode  = PMW_SLEEP;
                    st_nxt.ready = 1'b0;
                end
            end
            PMW_SLEEP: begin
                if (wr_wake || wf_hit || ed_hit) begin
                    st_nxt.mode      = PMW_SETTLE;
                    st_nxt.state     = PMW_ST_NORMAL;
                    st_nxt.settle    = 16'(READY_CYC);
                    st_nxt.read_seen = 1'b0;
                end
            end
            PMW_SETTLE: begin
                if (st_r.settle <= 16'h0001) begin
                    st_nxt.mode  = PMW_RUN;
                    st_nxt.ready = 1'b1;
                end
                st_nxt.settle = st_r.settle - 16'h0001;
            end
            default: begin
                st_nxt.mode = PMW_RUN;
            end
        endcase
        // Indication latches on an event, drops with cause or enables
        if (wf_hit || ed_hit) begin
            st_nxt.active = 1'b1;
        end else if (st_nxt.cause == 2'h0 || (!st_nxt.wfe && !st_nxt.ede)) begin
            st_nxt.active = 1'b0;
        end
        // Pin level: pulse or static, gated by the pin enable only
        pin_act = st_nxt.active && st_r.pen &&
                  (!st_r.pulse_sel || pulse_busy || pulse_start);
        if (!st_r.drive_type) begin
            st_nxt.pin_o  = 1'b0;
            st_nxt.pin_oe = pin_act;
        end else begin
            st_nxt.pin_o  = st_r.pol ? pin_act : !pin_act;
            st_nxt.pin_oe = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r       <= '0;
            st_r.mode  <= PMW_SETTLE;
            st_r.settle <= 16'(READY_CYC);
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata         = st_r.rdata;
    assign transceiver_reset = st_r.xrst;
    assign power_state       = st_r.state;
    assign device_ready      = st_r.ready;
    assign wake_interrupt    = st_r.active;
    assign wake_event_pin_o  = st_r.pin_o;
    assign wake_event_pin_oe = st_r.pin_oe;

    // Transceiver reset checks
    a_xrst_hold: assert property (@(posedge core_clk) disable iff (reset)
        $rose(st_r.xrst) |-> st_r.xrst [*8])
        else $error("transceiver reset too short");
    a_xrst_len: assert property (@(posedge core_clk) disable iff (reset)
        $fell(st_r.xrst) |-> st_r.xrst_len >= 32'(XRST_CYC))
        else $error("transceiver reset released early");
    a_xrst_ignore: assert property (@(posedge core_clk) disable iff (reset)
        st_r.xrst |-> !xrst_start)
        else $error("reset bit write taken while high");

    // Register port checks
    a_write_gate: assert property (@(posedge core_clk) disable iff (reset)
        (reg_wr && !st_r.read_seen && reg_addr == PMW_OFS_CTRL) |=> $stable(st_r.pen))
        else $error("write acted before read");
    a_rd_image: assert property (@(posedge core_clk) disable iff (reset)
        (reg_rd && reg_addr == PMW_OFS_CTRL) |=> reg_rdata[PMW_BIT_READY] == $past(st_r.ready))
        else $error("control read returned wrong ready");
    a_rd_idle: assert property (@(posedge core_clk) disable iff (reset)
        !reg_rd |=> reg_rdata == PMW_RD_UNMAPPED)
        else $error("read data outside read cycle");

    // Power state checks
    a_state_legal: assert property (@(posedge core_clk) disable iff (reset)
        st_r.state != 2'h3)
        else $error("reserved power state");
    a_wake_byte: assert property (@(posedge core_clk) disable iff (reset)
        (st_r.mode == PMW_SLEEP && reg_wr && reg_addr == PMW_OFS_BYTE_TEST)
            |=> st_r.mode == PMW_SETTLE)
        else $error("byte test write did not wake");
    a_sleep_unready: assert property (@(posedge core_clk) disable iff (reset)
        st_r.mode == PMW_SLEEP |-> !st_r.ready)
        else $error("ready while asleep");
    a_ready_wait: assert property (@(posedge core_clk) disable iff (reset)
        $rose(st_r.ready) |-> $past(st_r.mode) == PMW_SETTLE)
        else $error("ready without settling");
    a_ready_norm: assert property (@(posedge core_clk) disable iff (reset)
        $rose(st_r.ready) |-> st_r.state == PMW_ST_NORMAL)
        else $error("ready outside normal state");

    // Wake cause and interrupt checks
    a_int_raise: assert property (@(posedge core_clk) disable iff (reset)
        (st_r.wfe && wf_lvl) |=> st_r.active)
        else $error("wake frame missed interrupt");
    a_int_energy: assert property (@(posedge core_clk) disable iff (reset)
        (st_r.ede && ed_lvl) |=> st_r.active)
        else $error("energy event missed interrupt");
    a_cause_clr: assert property (@(posedge core_clk) disable iff (reset)
        (st_r.mode != PMW_RUN && st_r.cause[0] && ed_lvl) |=> st_r.cause[0])
        else $error("cause cleared too early");
    a_cause_keep: assert property (@(posedge core_clk) disable iff (reset)
        st_r.mode != PMW_RUN |=> (st_r.cause & $past(st_r.cause)) == $past(st_r.cause))
        else $error("cause bit dropped while not running");
    a_irq_drop: assert property (@(posedge core_clk) disable iff (reset)
        (st_r.cause == 2'h0 && !wf_hit && !ed_hit) |=> !st_r.active)
        else $error("indication kept without cause");

    // Wake pin drive checks
    a_od_low: assert property (@(posedge core_clk) disable iff (reset)
        (!st_r.drive_type && st_r.pin_oe) |-> !st_r.pin_o)
        else $error("open drain drove high");
    a_pp_drive: assert property (@(posedge core_clk) disable iff (reset)
        st_r.drive_type |=> st_r.pin_oe)
        else $error("push pull pin not driven");
    a_pin_gate: assert property (@(posedge core_clk) disable iff (reset)
        (!st_r.pen && st_r.drive_type && st_r.pol) |=> !st_r.pin_o)
        else $error("pin active while disabled");
    a_pulse_end: assert property (@(posedge core_clk) disable iff (reset)
        (st_r.pulse_sel && !st_r.drive_type && !pulse_busy && !pulse_start) |=> !st_r.pin_oe)
        else $error("pulsed pin held past its width");
endmodule : pmw_wake_ctrl

// [verif/pmw_host_model.sv]
// Host processor model that drives the register port of the wake control block
`timescale 1ns/10ps
module pmw_host_model
    import pmw_pkg::*;
(
    // Clock
    input  wire logic        core_clk,
    // Register port towards the block
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    // Bus idle at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write; address and data are inverted afterwards so stale values never look valid
    task automatic write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~addr;
        reg_wdata <= ~data;
    endtask : write

    // One-cycle read; data is taken in the single cycle after the strobe
    task automatic read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask : read
endmodule : pmw_host_model

// [verif/pmw_wake_ctrl_tb.sv]
// Self-checking testbench for the power management wake control block
`timescale 1ns/10ps
module pmw_wake_ctrl_tb
    import pmw_pkg::*;
;
    // Short counts keep the run brief
    localparam int XRST = 10;
    localparam int PULS = 20;
    logic        core_clk, reset, reg_wr, reg_rd, wake_frame_event, energy_event;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic        transceiver_reset, device_ready, wake_interrupt;
    logic        wake_event_pin_o, wake_event_pin_oe;
    logic [1:0]  power_state;
    int          err_count, num_checks, xrst_cycles;

    // Clock and time-zero values
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    // Counts every cycle the transceiver is held in reset
    always @(posedge core_clk) if (transceiver_reset === 1'b1) xrst_cycles++;

    pmw_wake_ctrl #(.XRST_CYC(XRST), .PULSE_CYC(PULS), .READY_CYC(4)) u_pmw_wake_ctrl (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wake_frame_event(wake_frame_event), .energy_event(energy_event),
        .transceiver_reset(transceiver_reset), .power_state(power_state),
        .device_ready(device_ready), .wake_interrupt(wake_interrupt),
        .wake_event_pin_o(wake_event_pin_o), .wake_event_pin_oe(wake_event_pin_oe));

    pmw_host_model u_pmw_host_model (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Control register read compared with an expected image
    task automatic rd_ctrl(input logic [31:0] exp);
        u_pmw_host_model.read(PMW_OFS_CTRL, rv);
        check("control", rv, exp);
    endtask : rd_ctrl

    // Waits on the ready pin without touching the bus, bounded
    task automatic wait_rdy;
        for (int i = 0; i < 100 && device_ready !== 1'b1; i++) @(posedge core_clk);
        #1;
        check("ready", {31'h0, device_ready}, 32'h1);
    endtask : wait_rdy

    // Events last long enough to pass the input synchroniser
    task automatic events(input logic wf, input logic ed);
        @(posedge core_clk);
        wake_frame_event <= wf;
        energy_event     <= ed;
        repeat (8) @(posedge core_clk);
        #1;
    endtask : events

    // Watchdog well beyond the expected run length
    initial begin
        #200us;
        err_count++;
        end_of_test();
    end

    initial begin
        err_count = 0;
        num_checks = 0;
        xrst_cycles = 0;
        reset = 1'b1;
        wake_frame_event = 1'b0;
        energy_event = 1'b0;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        check("outputs", {transceiver_reset, power_state, wake_interrupt,
                          wake_event_pin_oe, device_ready}, 32'h0);
        // Poll the ready bit by reads before anything else
        rv = 32'h0;
        for (int i = 0; i < 50 && rv[0] !== 1'b1; i++) begin
            u_pmw_host_model.read(PMW_OFS_CTRL, rv);
        end
        check("reset image", rv, 32'h00000001);
        // Reserved state code is refused and keeps normal operation
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00003000);
        rd_ctrl(32'h00000001);
        check("state pins", {30'h0, power_state}, 32'h0);
        // Transceiver reset: timed, self-clearing, second write ignored
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000400);
        rd_ctrl(32'h00000401);
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000400);
        repeat (XRST + 10) @(posedge core_clk);
        check("reset length", xrst_cycles, XRST + 1);
        rd_ctrl(32'h00000001);
        // Idle pin levels for each drive type and polarity
        // Pin registers follow the control bits one cycle after the write lands
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000040);
        @(posedge core_clk);
        #1;
        check("pp low idle", {wake_event_pin_oe, wake_event_pin_o}, 32'h3);
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000044);
        @(posedge core_clk);
        #1;
        check("pp high idle", {wake_event_pin_oe, wake_event_pin_o}, 32'h2);
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000000);
        @(posedge core_clk);
        #1;
        check("od idle", {31'h0, wake_event_pin_oe}, 32'h0);
        // Wake frame with push-pull active high static pin
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00001246);
        repeat (3) @(posedge core_clk);
        rd_ctrl(32'h00001246);
        events(1'b1, 1'b0);
        check("wf irq", {31'h0, wake_interrupt}, 32'h1);
        check("wf pin", {wake_event_pin_oe, wake_event_pin_o}, 32'h3);
        events(1'b0, 1'b0);
        wait_rdy();
        check("woke state", {30'h0, power_state}, 32'h0);
        // Write before any read after wake must be dropped
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000266);
        rd_ctrl(32'h00000267);
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000266);
        rd_ctrl(32'h00000247);
        check("wf cleared", {wake_interrupt, wake_event_pin_oe, wake_event_pin_o}, 32'h2);
        // Energy wake with pin disabled, open drain; source held during clear
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00002100);
        repeat (3) @(posedge core_clk);
        events(1'b0, 1'b1);
        check("ed irq", {31'h0, wake_interrupt}, 32'h1);
        check("ed pin off", {31'h0, wake_event_pin_oe}, 32'h0);
        wait_rdy();
        rd_ctrl(32'h00000111);
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000110);
        rd_ctrl(32'h00000111);
        events(1'b0, 1'b0);
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00000110);
        rd_ctrl(32'h00000101);
        // Both events, open drain pulsed pin
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h0000130a);
        repeat (3) @(posedge core_clk);
        events(1'b1, 1'b1);
        check("od active", {wake_event_pin_oe, wake_event_pin_o}, 32'h2);
        repeat (PULS + 10) @(posedge core_clk);
        #1;
        check("pulse over", {31'h0, wake_event_pin_oe}, 32'h0);
        events(1'b0, 1'b0);
        wait_rdy();
        rd_ctrl(32'h0000033b);
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h0000033a);
        rd_ctrl(32'h0000030b);
        check("irq cleared", {31'h0, wake_interrupt}, 32'h0);
        // Wake by a write to the byte-order test register alone
        u_pmw_host_model.write(PMW_OFS_CTRL, 32'h00001000);
        repeat (3) @(posedge core_clk);
        #1;
        check("asleep", {31'h0, device_ready}, 32'h0);
        u_pmw_host_model.write(PMW_OFS_BYTE_TEST, 32'h5a5a0f0f);
        wait_rdy();
        check("byte wake state", {30'h0, power_state}, 32'h0);
        rd_ctrl(32'h00000001);
        // Unmapped address reads as zero
        u_pmw_host_model.read(8'h70, rv);
        check("unmapped", rv, PMW_RD_UNMAPPED);
        end_of_test();
    end
endmodule : pmw_wake_ctrl_tb
